//--- rtl/spt_params.svh
`ifndef SPT_PARAMS_SVH
`define SPT_PARAMS_SVH
`define SPT_BUF_DEPTH 11'h400
`define SPT_CNT_W 11
`define SPT_PTR_W 10
`define SPT_HOSTS 8
`define SPT_LIM_W 4
`define SPT_ONE_HOST 4'h1
`define SPT_PARAM_W 16
`define SPT_PARAM_RESET 16'h0000
`define SPT_LINE_RESET 1'b1
`define SPT_MS_W 16
`define SPT_PRESC_W 17
`define SPT_MS_NS 1000000
`define SPT_CLK_NS 10
`define SPT_SKID_DEPTH 2'h2
`endif

//--- rtl/spt_pkg.sv
`include "spt_params.svh"
package spt_pkg;
   typedef enum logic [1:0]
   {
      SPT_COLLECT = 2'b01,
      SPT_DRAIN = 2'b10
   } spt_state_t;

   typedef enum logic [1:0]
   {
      SPT_ACT_NONE = 2'h0,
      SPT_ACT_PLUS1 = 2'h1,
      SPT_ACT_PLUS2 = 2'h2,
      SPT_ACT_STRIP = 2'h3
   } spt_action_t;

   typedef struct packed
   {
      spt_state_t state;
      logic [`SPT_CNT_W-1:0] count;
      logic [`SPT_CNT_W-1:0] left;
      logic [`SPT_PTR_W-1:0] rd_ptr;
      logic prev_d1;
      logic [1:0] tail;
      logic [`SPT_PRESC_W-1:0] presc;
      logic [`SPT_MS_W-1:0] ms;
      logic rts;
      logic dtr;
      logic rts_line;
      logic dtr_line;
      logic [`SPT_PARAM_W-1:0] host_param;
      logic [`SPT_PARAM_W-1:0] param;
   } spt_core_t;
endpackage : spt_pkg

//--- rtl/spt_skid.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_skid
   import spt_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   typedef struct packed
   {
      logic [1:0][W-1:0] slot;
      logic wr;
      logic rd;
      logic [1:0] count;
   } spt_skid_t;

   spt_skid_t cur;
   spt_skid_t next_cur;
   logic push;
   logic pop;

   // handshakes drop while frozen so no word moves unseen
   assign in_ready_out = ce_in && (cur.count != `SPT_SKID_DEPTH);
   assign out_valid_out = ce_in && (cur.count != 2'h0);
   assign out_data_out = cur.slot[cur.rd];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // two slots used in turn keep words in arrival order
   always_comb
   begin
      next_cur = cur;
      if (push)
      begin
         next_cur.slot[cur.wr] = in_data_in;
         next_cur.wr = ~cur.wr;
      end
      if (pop)
         next_cur.rd = ~cur.rd;
      if (push && !pop)
         next_cur.count = cur.count + 2'h1;
      else if (pop && !push)
         next_cur.count = cur.count - 2'h1;
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         cur <= '0;
      else if (ce_in)
         cur <= next_cur;
   end
endmodule : spt_skid

//--- rtl/spt_tunnel.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_tunnel
   import spt_pkg::*;
#(
   parameter int CYCLES_PER_MS = `SPT_MS_NS / `SPT_CLK_NS
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // serial receive side
   input wire logic ser_rx_valid_in,
   input wire logic [7:0] ser_rx_data_in,
   output logic ser_rx_ready_out,
   // packing configuration
   input wire logic [`SPT_CNT_W-1:0] pack_limit_in,
   input wire logic [7:0] delim1_in,
   input wire logic delim1_en_in,
   input wire logic [7:0] delim2_in,
   input wire logic delim2_en_in,
   input wire logic [1:0] delim_action_in,
   input wire logic [`SPT_MS_W-1:0] force_timeout_ms_in,
   // host handling configuration and status
   input wire logic [`SPT_LIM_W-1:0] host_limit_in,
   input wire logic [`SPT_HOSTS-1:0] host_open_in,
   input wire logic skip_stalled_host_in,
   input wire logic allow_host_ctrl_in,
   input wire logic link_up_in,
   input wire logic link_loss_low_in,
   input wire logic host_ctrl_valid_in,
   input wire logic host_rts_in,
   input wire logic host_dtr_in,
   input wire logic host_param_valid_in,
   input wire logic [`SPT_PARAM_W-1:0] host_param_in,
   input wire logic [`SPT_PARAM_W-1:0] stored_param_in,
   // packets toward the hosts
   output logic net_tx_valid_out,
   output logic [7:0] net_tx_data_out,
   output logic net_tx_last_out,
   output logic [`SPT_HOSTS-1:0] net_tx_host_mask_out,
   input wire logic [`SPT_HOSTS-1:0] host_ready_in,
   output logic [`SPT_HOSTS-1:0] host_grant_out,
   output logic multi_host_out,
   // network to serial path
   input wire logic net_rx_valid_in,
   input wire logic [7:0] net_rx_data_in,
   output logic net_rx_ready_out,
   output logic ser_tx_valid_out,
   output logic [7:0] ser_tx_data_out,
   input wire logic ser_tx_ready_in,
   // serial lines and parameters
   output logic rts_out,
   output logic dtr_out,
   output logic [`SPT_PARAM_W-1:0] serial_param_out
);
   localparam logic [`SPT_PRESC_W-1:0] PRESC_LAST =
      `SPT_PRESC_W'(CYCLES_PER_MS - 1);

   spt_core_t cur;
   spt_core_t next_cur;
   logic [7:0] buf_mem [0:`SPT_BUF_DEPTH-1];

   logic accept;
   logic is_d1;
   logic pair_mode;
   logic match;
   logic strip;
   logic store;
   logic flush;
   logic timed_out;
   logic [`SPT_CNT_W-1:0] cnt_new;
   logic [`SPT_PTR_W-1:0] wr_addr;
   logic wr_en;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [8:0] buf_in_word;
   logic [8:0] buf_out_word;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [`SPT_HOSTS-1:0] limit_mask;
   logic [`SPT_HOSTS-1:0] active;
   logic [`SPT_HOSTS-1:0] ready_active;
   logic multi;
   logic ctrl_taken;

   // hosts whose index lies under the limit may hold the port
   for (genvar i = 0; i < `SPT_HOSTS; i++)
   begin : g_host
      assign limit_mask[i] = `SPT_LIM_W'(i) < host_limit_in;
   end

   assign active = host_open_in & limit_mask;
   assign host_grant_out = active;
   assign multi = host_limit_in > `SPT_ONE_HOST;
   assign multi_host_out = multi;
   assign ready_active = active & host_ready_in;

   // fan-out: without skipping, the slowest granted host paces everyone
   always_comb
   begin
      if (active == '0)
      begin
         buf_out_ready = 1'b1;
         net_tx_host_mask_out = '0;
      end
      else if (skip_stalled_host_in && multi)
      begin
         buf_out_ready = |ready_active;
         net_tx_host_mask_out = ready_active;
      end
      else
      begin
         buf_out_ready = ready_active == active;
         net_tx_host_mask_out = active;
      end
   end

   assign net_tx_valid_out = buf_out_valid;
   assign net_tx_data_out = buf_out_word[7:0];
   assign net_tx_last_out = buf_out_word[8];

   // new serial bytes wait while a packet drains out
   assign ser_rx_ready_out = ce_in && (cur.state == SPT_COLLECT);
   assign accept = ser_rx_valid_in && ser_rx_ready_out;

   // delimiter decode for the current byte
   always_comb
   begin
      pair_mode = delim1_en_in && delim2_en_in;
      is_d1 = delim1_en_in && (ser_rx_data_in == delim1_in);
      if (cur.tail != 2'h0)
         match = 1'b0;
      else if (pair_mode)
         match = cur.prev_d1 && (ser_rx_data_in == delim2_in);
      else
         match = is_d1;
      strip = match && (delim_action_in == SPT_ACT_STRIP);
      store = !strip;
   end

   // new count after this byte; a stripped pair also takes back its head
   always_comb
   begin
      cnt_new = cur.count;
      if (store)
         cnt_new = cur.count + `SPT_CNT_W'(1);
      else if (pair_mode && (cur.count != '0))
         cnt_new = cur.count - `SPT_CNT_W'(1);
   end

   assign wr_addr = cur.count[`SPT_PTR_W-1:0];
   assign wr_en = accept && store;

   // expiry counts from the last byte, only with data waiting
   assign timed_out = (force_timeout_ms_in != '0) &&
      (cur.count != '0) && (cur.ms == force_timeout_ms_in);

   // which conditions end a packet on this byte
   always_comb
   begin
      flush = 1'b0;
      if (accept)
      begin
         if (cur.tail == 2'h1)
            flush = 1'b1;
         if (match && (delim_action_in == SPT_ACT_NONE))
            flush = 1'b1;
         if (strip)
            flush = 1'b1;
         if ((pack_limit_in != '0) && (cnt_new == pack_limit_in))
            flush = 1'b1;
         if (cnt_new == `SPT_BUF_DEPTH)
            flush = 1'b1;
      end
      else if (cur.state == SPT_COLLECT)
         flush = timed_out;
   end

   assign ctrl_taken = host_ctrl_valid_in && (!multi || allow_host_ctrl_in);

   // drain feeds the outgoing buffer straight from the packet store
   assign buf_in_valid = cur.state == SPT_DRAIN;
   assign buf_in_word = {cur.left == `SPT_CNT_W'(1), buf_mem[cur.rd_ptr]};

   // main state update; everything freezes while the enable is low
   always_comb
   begin
      next_cur = cur;
      if (ce_in)
      begin
         case (cur.state)
            SPT_COLLECT:
            begin
               if (cur.count != '0)
               begin
                  if (cur.presc == PRESC_LAST)
                  begin
                     next_cur.presc = '0;
                     if (cur.ms != force_timeout_ms_in)
                        next_cur.ms = cur.ms + `SPT_MS_W'(1);
                  end
                  else
                     next_cur.presc = cur.presc + `SPT_PRESC_W'(1);
               end
               if (accept)
               begin
                  // every byte restarts the inter-byte interval
                  next_cur.presc = '0;
                  next_cur.ms = '0;
                  next_cur.count = cnt_new;
                  next_cur.prev_d1 = is_d1 && !match;
                  if (cur.tail != 2'h0)
                     next_cur.tail = cur.tail - 2'h1;
                  else if (match && (delim_action_in == SPT_ACT_PLUS1))
                     next_cur.tail = 2'h1;
                  else if (match && (delim_action_in == SPT_ACT_PLUS2))
                     next_cur.tail = 2'h2;
               end
               if (flush)
               begin
                  // a flush with nothing stored sends no empty packet
                  next_cur.count = '0;
                  next_cur.prev_d1 = 1'b0;
                  next_cur.tail = 2'h0;
                  next_cur.presc = '0;
                  next_cur.ms = '0;
                  next_cur.rd_ptr = '0;
                  next_cur.left = accept ? cnt_new : cur.count;
                  if (next_cur.left != '0)
                     next_cur.state = SPT_DRAIN;
               end
            end
            SPT_DRAIN:
            begin
               if (buf_in_ready)
               begin
                  next_cur.rd_ptr = cur.rd_ptr + `SPT_PTR_W'(1);
                  next_cur.left = cur.left - `SPT_CNT_W'(1);
                  if (cur.left == `SPT_CNT_W'(1))
                     next_cur.state = SPT_COLLECT;
               end
            end
            default:
            begin
               next_cur.state = SPT_COLLECT;
               next_cur.count = '0;
            end
         endcase

         // control commands: latest accepted one wins
         if (ctrl_taken)
         begin
            next_cur.rts = host_rts_in;
            next_cur.dtr = host_dtr_in;
         end
         // single host alone may set the serial parameters
         if (host_param_valid_in && !multi)
            next_cur.host_param = host_param_in;
         next_cur.param = multi ? stored_param_in : next_cur.host_param;
         // link loss may pull both lines low; high option leaves them
         if (link_loss_low_in && !link_up_in)
         begin
            next_cur.rts_line = 1'b0;
            next_cur.dtr_line = 1'b0;
         end
         else
         begin
            next_cur.rts_line = next_cur.rts;
            next_cur.dtr_line = next_cur.dtr;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         cur <= '0;
         cur.state <= SPT_COLLECT;
         cur.rts <= `SPT_LINE_RESET;
         cur.dtr <= `SPT_LINE_RESET;
         cur.rts_line <= `SPT_LINE_RESET;
         cur.dtr_line <= `SPT_LINE_RESET;
         cur.host_param <= `SPT_PARAM_RESET;
         cur.param <= `SPT_PARAM_RESET;
      end
      else
         cur <= next_cur;
   end

   // packet store has no reset; only written slots are ever read
   always_ff @(posedge clock_in)
   begin
      if (ce_in && wr_en)
         buf_mem[wr_addr] <= ser_rx_data_in;
   end

   assign rts_out = cur.rts_line;
   assign dtr_out = cur.dtr_line;
   assign serial_param_out = cur.param;

   // outgoing buffer absorbs host stalls without losing a byte
   spt_skid #(.W(9)) u_tx_buf
   (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .in_valid_in(buf_in_valid),
      .in_data_in(buf_in_word),
      .in_ready_out(buf_in_ready),
      .out_valid_out(buf_out_valid),
      .out_data_out(buf_out_word),
      .out_ready_in(buf_out_ready)
   );

   // network bytes pass to the serial side in arrival order
   spt_skid #(.W(8)) u_rx_buf
   (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .in_valid_in(net_rx_valid_in),
      .in_data_in(net_rx_data_in),
      .in_ready_out(net_rx_ready_out),
      .out_valid_out(ser_tx_valid_out),
      .out_data_out(ser_tx_data_out),
      .out_ready_in(ser_tx_ready_in)
   );
endmodule : spt_tunnel

//--- verification/spt_tunnel_properties.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_tunnel_properties
#(
   parameter int CYCLES_PER_MS = 10
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic ser_rx_valid_in,
   input wire logic ser_rx_ready_out,
   input wire logic [`SPT_CNT_W-1:0] pack_limit_in,
   input wire logic [`SPT_MS_W-1:0] force_timeout_ms_in,
   input wire logic [`SPT_LIM_W-1:0] host_limit_in,
   input wire logic skip_stalled_host_in,
   input wire logic allow_host_ctrl_in,
   input wire logic link_up_in,
   input wire logic link_loss_low_in,
   input wire logic host_ctrl_valid_in,
   input wire logic host_rts_in,
   input wire logic host_dtr_in,
   input wire logic [`SPT_PARAM_W-1:0] stored_param_in,
   input wire logic net_tx_valid_out,
   input wire logic [`SPT_HOSTS-1:0] net_tx_host_mask_out,
   input wire logic [`SPT_HOSTS-1:0] host_ready_in,
   input wire logic [`SPT_HOSTS-1:0] host_grant_out,
   input wire logic multi_host_out,
   input wire logic rts_out,
   input wire logic dtr_out,
   input wire logic [`SPT_PARAM_W-1:0] serial_param_out
);
   logic [`SPT_CNT_W-1:0] cnt;
   int idle;
   // bytes taken since the last drain, idle cycles since the last byte
   always_ff @(posedge clock_in)
   begin
      if (rst_in || !ser_rx_ready_out)
      begin
         cnt <= '0;
         idle <= 0;
      end
      else if (ser_rx_valid_in)
      begin
         cnt <= cnt + 1'b1;
         idle <= 0;
      end
      else if (cnt != '0)
         idle <= idle + 1;
   end
   default clocking cb @(posedge clock_in); endclocking
   // a frozen enable holds every register, so no rule may move then
   default disable iff (rst_in || !ce_in);
   a_reset_lines_high:
      assert property (disable iff (1'b0) rst_in |=> rts_out && dtr_out
         && serial_param_out == '0 && !net_tx_valid_out)
      else $error("reset state wrong");
   a_link_loss_low:
      assert property (!link_up_in && link_loss_low_in |=>
         !rts_out && !dtr_out)
      else $error("lines not low on link loss");
   // the command and line registers update on the same edge
   a_ctrl_taken:
      assert property (host_ctrl_valid_in && link_up_in && (allow_host_ctrl_in
         || host_limit_in == `SPT_ONE_HOST) |=> rts_out ==
         $past(host_rts_in) && dtr_out == $past(host_dtr_in))
      else $error("control command not applied");
   a_ctrl_dropped:
      assert property (host_ctrl_valid_in && multi_host_out && link_up_in
         && $past(link_up_in) && !allow_host_ctrl_in |=> $stable(rts_out)
         && $stable(dtr_out))
      else $error("control command not dropped");
   a_stored_param:
      assert property (multi_host_out |=>
         serial_param_out == $past(stored_param_in))
      else $error("stored parameters not used");
   a_single_grant:
      assert property (host_limit_in == `SPT_ONE_HOST |->
         $countones(host_grant_out) <= 1)
      else $error("more than one host granted");
   a_skip_mask:
      assert property (net_tx_valid_out && skip_stalled_host_in
         && multi_host_out |-> net_tx_host_mask_out ==
         (host_ready_in & host_grant_out))
      else $error("stalled host not skipped");
   a_length_limit:
      assert property (pack_limit_in != '0 |-> cnt <= pack_limit_in)
      else $error("byte limit exceeded");
   a_buffer_full:
      assert property (cnt <= `SPT_BUF_DEPTH)
      else $error("buffer overfilled");
   a_timeout_flush:
      assert property (force_timeout_ms_in != '0 |->
         idle <= force_timeout_ms_in * CYCLES_PER_MS + 3)
      else $error("timeout flush late");
   c_skip: cover property (net_tx_valid_out && skip_stalled_host_in);
   c_full: cover property (cnt == `SPT_BUF_DEPTH);
   c_idle: cover property (force_timeout_ms_in != '0 && idle > 50);
endmodule : spt_tunnel_properties
bind spt_tunnel spt_tunnel_properties #(.CYCLES_PER_MS(CYCLES_PER_MS))
   chk_u (.*);

//--- verification/spt_host_model.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_host_model
(
   input wire logic clock_in,
   input wire logic [`SPT_HOSTS-1:0] stall_in,
   input wire logic slow_in,
   output logic [`SPT_HOSTS-1:0] host_ready_out
);
   logic phase = 1'b1;
   // slow hosts take a byte only every other cycle, stalled ones never
   always @(negedge clock_in)
      phase <= slow_in ? ~phase : 1'b1;
   assign host_ready_out = phase ? ~stall_in : '0;
endmodule : spt_host_model

//--- verification/spt_tunnel_tb.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_tunnel_tb;
   import spt_pkg::*;
   typedef logic [7:0] spt_bytes_t[$];
   logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, slow = 1'b0;
   logic ser_rx_valid_in = 1'b0, delim1_en_in = 1'b0;
   logic delim2_en_in = 1'b0, skip_stalled_host_in = 1'b0;
   logic allow_host_ctrl_in = 1'b0, link_up_in = 1'b1;
   logic link_loss_low_in = 1'b0, host_ctrl_valid_in = 1'b0;
   logic host_rts_in = 1'b1, host_dtr_in = 1'b1;
   logic host_param_valid_in = 1'b0, net_rx_valid_in = 1'b0;
   logic ser_tx_ready_in = 1'b0;
   logic [1:0] delim_action_in = 2'h0;
   logic [7:0] ser_rx_data_in = 8'h00, delim1_in = 8'h0D;
   logic [7:0] delim2_in = 8'h0A, net_rx_data_in = 8'h00;
   logic [`SPT_CNT_W-1:0] pack_limit_in = '0;
   logic [`SPT_MS_W-1:0] force_timeout_ms_in = '0;
   logic [`SPT_LIM_W-1:0] host_limit_in = `SPT_ONE_HOST;
   logic [`SPT_HOSTS-1:0] host_open_in = 8'h03, stall = 8'h00;
   logic [`SPT_HOSTS-1:0] host_ready_in, net_tx_host_mask_out;
   logic [`SPT_HOSTS-1:0] host_grant_out;
   logic [`SPT_PARAM_W-1:0] host_param_in = 16'hBEEF;
   logic [`SPT_PARAM_W-1:0] stored_param_in = 16'h1234, serial_param_out;
   logic ser_rx_ready_out, net_tx_valid_out, net_tx_last_out;
   logic multi_host_out, net_rx_ready_out, ser_tx_valid_out;
   logic rts_out, dtr_out;
   logic [7:0] net_tx_data_out, ser_tx_data_out;
   spt_bytes_t got, sent, big;
   int err_count = 0, checked = 0, pkts = 0;
   // short millisecond keeps timeout runs brief
   spt_tunnel #(.CYCLES_PER_MS(10)) dut_u (.*);
   spt_host_model host_u (.clock_in(clock_in), .stall_in(stall),
      .slow_in(slow), .host_ready_out(host_ready_in));
   initial forever #5 clock_in = ~clock_in;
   // a byte counts only once every host on the mask takes it
   always @(posedge clock_in)
   begin
      if (net_tx_valid_out && net_tx_host_mask_out != '0
         && (net_tx_host_mask_out & ~host_ready_in) == '0)
      begin
         got.push_back(net_tx_data_out);
         if (net_tx_last_out) pkts++;
      end
      if (ser_tx_valid_out && ser_tx_ready_in)
         sent.push_back(ser_tx_data_out);
   end
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check
   function automatic logic same(input spt_bytes_t a, b);
      same = a.size() == b.size();
      foreach (b[i])
         if (same && a[i] !== b[i]) same = 1'b0;
   endfunction : same
   // holds valid across bytes so back-to-back bytes need no gap
   task automatic send(input spt_bytes_t q);
      foreach (q[i])
      begin
         ser_rx_data_in = q[i];
         ser_rx_valid_in = 1'b1;
         while (ser_rx_ready_out !== 1'b1) @(negedge clock_in);
         @(negedge clock_in);
      end
      ser_rx_valid_in = 1'b0;
   endtask : send
   task automatic expect_pkt(input spt_bytes_t x);
      repeat (3000)
         if (pkts == 0) @(negedge clock_in);
      check(pkts == 1 && same(got, x), "packet bytes differ");
      got = {};
      pkts = 0;
   endtask : expect_pkt
   task automatic pkt(input spt_bytes_t q, x);
      send(q);
      expect_pkt(x);
   endtask : pkt
   task automatic ctrl(input logic r, input logic d);
      host_rts_in = r;
      host_dtr_in = d;
      host_ctrl_valid_in = 1'b1;
      @(negedge clock_in);
      host_ctrl_valid_in = 1'b0;
      repeat (4) @(negedge clock_in);
   endtask : ctrl
   task automatic complete_run();
      $display("err_count=%0d checked=%0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   // cut a hang short well past the expected run length
   initial
   begin
      #300000;
      err_count++;
      complete_run();
   end
   initial
   begin
      repeat (16) @(negedge clock_in);
      check(rts_out && dtr_out && serial_param_out === '0, "reset");
      rst_in = 1'b0;
      delim1_en_in = 1'b1;
      send('{8'h11, 8'h22});
      repeat (60) @(negedge clock_in);
      check(got.size() == 0, "flushed with timeout off");
      pkt('{8'h0D}, '{8'h11, 8'h22, 8'h0D});
      delim_action_in = 2'h1;
      pkt('{8'h44, 8'h0D, 8'h55}, '{8'h44, 8'h0D, 8'h55});
      delim_action_in = 2'h2;
      pkt('{8'h0D, 8'h55, 8'h66}, '{8'h0D, 8'h55, 8'h66});
      delim_action_in = 2'h3;
      pkt('{8'h44, 8'h0D}, '{8'h44});
      delim2_en_in = 1'b1;
      pkt('{8'h77, 8'h0D, 8'h0A}, '{8'h77});
      delim_action_in = 2'h0;
      pkt('{8'h0D, 8'h44, 8'h0D, 8'h0A},
         '{8'h0D, 8'h44, 8'h0D, 8'h0A});
      delim1_en_in = 1'b0;
      delim2_en_in = 1'b0;
      pack_limit_in = 11'h003;
      pkt('{8'h01, 8'h02, 8'h03}, '{8'h01, 8'h02, 8'h03});
      pack_limit_in = 11'h000;
      for (int i = 0; i < 1024; i++) big.push_back(i[7:0]);
      pkt(big, big);
      force_timeout_ms_in = 16'h000B;
      send('{8'h98, 8'h99});
      repeat (60) @(negedge clock_in);
      check(got.size() == 0, "timeout flushed early");
      expect_pkt('{8'h98, 8'h99});
      delim1_en_in = 1'b1;
      host_limit_in = 4'h2;
      stall = 8'h02;
      send('{8'h0D});
      repeat (40) @(negedge clock_in);
      check(got.size() == 0 && net_tx_valid_out, "did not wait");
      check(host_grant_out === 8'h03 && multi_host_out, "shared");
      stall = 8'h00;
      slow = 1'b1;
      expect_pkt('{8'h0D});
      skip_stalled_host_in = 1'b1;
      stall = 8'h02;
      pkt('{8'h0D}, '{8'h0D});
      check(serial_param_out === 16'h1234, "stored param");
      ctrl(1'b0, 1'b0);
      check(rts_out === 1'b1, "command not dropped");
      allow_host_ctrl_in = 1'b1;
      ctrl(1'b0, 1'b0);
      check(rts_out === 1'b0 && dtr_out === 1'b0, "command lost");
      ctrl(1'b1, 1'b0);
      check(rts_out === 1'b1 && dtr_out === 1'b0, "latest lost");
      link_loss_low_in = 1'b1;
      link_up_in = 1'b0;
      repeat (2) @(negedge clock_in);
      check(rts_out === 1'b0 && dtr_out === 1'b0, "link loss");
      link_loss_low_in = 1'b0;
      repeat (2) @(negedge clock_in);
      check(rts_out === 1'b1 && dtr_out === 1'b0, "link ignored");
      host_limit_in = `SPT_ONE_HOST;
      host_param_valid_in = 1'b1;
      @(negedge clock_in);
      host_param_valid_in = 1'b0;
      repeat (3) @(negedge clock_in);
      check(serial_param_out === 16'hBEEF, "host param");
      check(host_grant_out === 8'h01, "single grant");
      net_rx_valid_in = 1'b1;
      for (int i = 1; i < 6; i++)
      begin
         net_rx_data_in = 8'hA0 + i[7:0];
         if (i == 3) check(net_rx_ready_out === 1'b0, "not full");
         if (i == 3) ser_tx_ready_in = 1'b1;
         while (net_rx_ready_out !== 1'b1) @(negedge clock_in);
         @(negedge clock_in);
      end
      net_rx_valid_in = 1'b0;
      repeat (10) @(negedge clock_in);
      check(same(sent, '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5}),
         "order");
      // low enable must freeze the lines and close the serial input
      ce_in = 1'b0;
      ctrl(1'b0, 1'b0);
      check(rts_out === 1'b1 && ser_rx_ready_out === 1'b0, "not frozen");
      ce_in = 1'b1;
      complete_run();
   end
endmodule : spt_tunnel_tb
